// *** rtl/vlp_pkg.sv ***
// ************************************************************
// vanc line placement shared definitions
// ************************************************************
package vlp_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] VLP_OFS_CTRL    = 8'h00; // enable and output format
    localparam logic [7:0] VLP_OFS_STATUS  = 8'h04; // sticky events, write one to clear
    localparam logic [7:0] VLP_OFS_MASK    = 8'h08; // interrupt mask, same layout
    localparam logic [7:0] VLP_OFS_HEALTH  = 8'h0c; // indicator levels, read only
    localparam logic [7:0] VLP_OFS_REQ     = 8'h20; // requested line, one word per item
    localparam logic [7:0] VLP_OFS_APPLIED = 8'h40; // applied line, one word per item

    // ************************************************************
    // field positions and sizes
    // ************************************************************
    localparam int VLP_NITEM      = 6;  // placed ancillary items
    localparam int VLP_LW         = 6;  // width of a line number
    localparam int VLP_CTRL_EN    = 0;  // insertion enable bit
    localparam int VLP_CTRL_FMT   = 1;  // lowest bit of format field
    localparam int VLP_NEV        = 3;  // sticky events
    localparam int VLP_EV_CLAMP   = 0;  // a request was moved to a bound, or to line 21 for sd captions
    localparam int VLP_EV_INSERT  = 1;  // an item was placed on a line
    localparam int VLP_EV_BADFMT  = 2;  // format code is illegal
    localparam int VLP_HL_FMT     = 0;  // format indicator, bits 1:0
    localparam int VLP_HL_PLACE   = 2;  // placement indicator, bits 3:2
    localparam int VLP_HL_INS     = 4;  // insertion indicator, bits 5:4

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic       VLP_RST_EN   = 1'b0;
    localparam logic [2:0] VLP_RST_FMT  = 3'h0;
    localparam logic [2:0] VLP_RST_MASK = 3'h0;
    localparam logic [7:0] VLP_RST_REQ  = 8'h00; // zero means use the default line

    // ************************************************************
    // output formats, item numbers, indicator levels
    // ************************************************************
    localparam logic [2:0] VLP_F525I  = 3'h0;
    localparam logic [2:0] VLP_F625I  = 3'h1;
    localparam logic [2:0] VLP_F720P  = 3'h2;
    localparam logic [2:0] VLP_F1080I = 3'h3;
    localparam logic [2:0] VLP_F1080P = 3'h4;

    localparam logic [2:0] VLP_IT_AFD  = 3'h0; // active format description
    localparam logic [2:0] VLP_IT_AVIT = 3'h1; // ancillary timecode, vitc form
    localparam logic [2:0] VLP_IT_ALTC = 3'h2; // ancillary timecode, ltc form
    localparam logic [2:0] VLP_IT_AMD  = 3'h3; // audio metadata
    localparam logic [2:0] VLP_IT_WAVE = 3'h4; // sd vitc waveform
    localparam logic [2:0] VLP_IT_CAP  = 3'h5; // closed captions

    localparam logic [1:0] VLP_LV_NORMAL  = 2'h0;
    localparam logic [1:0] VLP_LV_ALERT   = 2'h1;
    localparam logic [1:0] VLP_LV_FAILURE = 2'h2;

    // ************************************************************
    // line numbers
    // ************************************************************
    localparam logic [5:0] VLP_L_NONE = 6'h00; // item not carried
    localparam logic [5:0] VLP_L8     = 6'h08;
    localparam logic [5:0] VLP_L9     = 6'h09;
    localparam logic [5:0] VLP_L10    = 6'h0a;
    localparam logic [5:0] VLP_L12    = 6'h0c;
    localparam logic [5:0] VLP_L13    = 6'h0d;
    localparam logic [5:0] VLP_L14    = 6'h0e;
    localparam logic [5:0] VLP_L19    = 6'h13;
    localparam logic [5:0] VLP_L20    = 6'h14;
    localparam logic [5:0] VLP_L21    = 6'h15;
    localparam logic [5:0] VLP_L22    = 6'h16;
    localparam logic [5:0] VLP_L25    = 6'h19;
    localparam logic [5:0] VLP_L41    = 6'h29;

    // ************************************************************
    // bus answers
    // ************************************************************
    localparam logic [1:0] VLP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] VLP_RESP_SLVERR = 2'h2;

    // read sequencer states
    typedef enum logic [1:0] {VLP_RD_IDLE, VLP_RD_FETCH, VLP_RD_RESP} vlp_rd_t;

    // format code is one of the five known outputs
    function automatic logic vlp_fmt_ok(input logic [2:0] fmt);
        return fmt <= VLP_F1080P;
    endfunction : vlp_fmt_ok

    // standard definition outputs
    function automatic logic vlp_is_sd(input logic [2:0] fmt);
        return (fmt == VLP_F525I) || (fmt == VLP_F625I);
    endfunction : vlp_is_sd

    // lowest line an item may use
    function automatic logic [5:0] vlp_lo(input logic [2:0] fmt);
        return (fmt == VLP_F525I) ? VLP_L12 : VLP_L9;
    endfunction : vlp_lo

    // highest line an item may use, sd captions excepted, keeps active picture intact
    function automatic logic [5:0] vlp_hi(input logic [2:0] fmt);
        logic [5:0] hi;
        hi = VLP_L19;
        unique case (fmt)
            VLP_F525I:  hi = VLP_L19;
            VLP_F625I:  hi = VLP_L22;
            VLP_F720P:  hi = VLP_L25;
            VLP_F1080I: hi = VLP_L20;
            VLP_F1080P: hi = VLP_L41;
            default:    hi = VLP_L19;
        endcase
        return hi;
    endfunction : vlp_hi

    // default line per item, none where the item is not carried
    function automatic logic [5:0] vlp_default(input logic [2:0] item, input logic sd);
        logic [5:0] d;
        d = VLP_L_NONE;
        unique case (item)
            VLP_IT_AFD:  d = sd ? VLP_L12 : VLP_L9;
            VLP_IT_AVIT: d = sd ? VLP_L13 : VLP_L9;
            VLP_IT_ALTC: d = sd ? VLP_L_NONE : VLP_L10;
            VLP_IT_AMD:  d = VLP_L13;
            VLP_IT_WAVE: d = sd ? VLP_L14 : VLP_L_NONE;
            VLP_IT_CAP:  d = sd ? VLP_L21 : VLP_L10;
            default:     d = VLP_L_NONE;
        endcase
        return d;
    endfunction : vlp_default

endpackage : vlp_pkg

// *** rtl/vlp_line_mem.sv ***
`timescale 1ns/1ns
// ************************************************************
// requested line store, one write port, two registered reads
// ************************************************************
module vlp_line_mem
    import vlp_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // write port
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // bus read port
    input  wire logic [2:0] rd_a_addr,
    output logic      [7:0] rd_a_data,
    // scanner read port
    input  wire logic [2:0] rd_b_addr,
    output logic      [7:0] rd_b_data
);

    // all state of the store
    typedef struct packed {
        logic [VLP_NITEM-1:0][7:0] word; // stored requests
        logic [7:0]                a;    // bus read data
        logic [7:0]                b;    // scanner read data
    } vlp_mem_t;

    vlp_mem_t st;      // current state
    vlp_mem_t next_st; // next state

    // write and both reads
    always_comb begin
        next_st = st;
        if (wr_en && (wr_addr < 3'(VLP_NITEM))) begin
            next_st.word[wr_addr] = wr_data;
        end
        next_st.a = (rd_a_addr < 3'(VLP_NITEM)) ? st.word[rd_a_addr] : 8'h00;
        next_st.b = (rd_b_addr < 3'(VLP_NITEM)) ? st.word[rd_b_addr] : 8'h00;
    end

    // state register, all words start at the default marker
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{word: {VLP_NITEM{VLP_RST_REQ}}, a: 8'h00, b: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign rd_a_data = st.a;
    assign rd_b_data = st.b;

endmodule : vlp_line_mem

// *** rtl/vlp_top.sv ***
`timescale 1ns/1ns
module vlp_top
    import vlp_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    // video timing
    input  wire logic        LINE_STB,
    input  wire logic [10:0] LINE_NUM,
    // insertion strobes and interrupt
    output logic      [5:0]  VANC_INS,
    output logic             IRQ,
    // axi4-lite write address
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    // axi4-lite write data
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // axi4-lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic      [1:0]  S_AXI_BRESP,
    // axi4-lite read address
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    // axi4-lite read data
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic      [31:0] S_AXI_RDATA,
    output logic      [1:0]  S_AXI_RRESP
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                          aw_held;  // write address captured
        logic [7:0]                    aw_addr;  // captured write address
        logic                          w_held;   // write data captured
        logic [31:0]                   w_data;   // captured write data
        logic [3:0]                    w_strb;   // captured byte enables
        logic                          bvalid;   // write answer pending
        logic [1:0]                    bresp;    // write answer code
        vlp_rd_t                       rd;       // read sequencer
        logic [7:0]                    ar_addr;  // captured read address
        logic [31:0]                   rdata;    // register read data
        logic [1:0]                    rresp;    // read answer code
        logic                          enable;   // insertion enable
        logic [2:0]                    fmt;      // output format
        logic [VLP_NEV-1:0]            status;   // sticky events
        logic [VLP_NEV-1:0]            mask;     // interrupt mask
        logic [2:0]                    scan;     // item being read
        logic [2:0]                    scan_q;   // item whose data is back
        logic                          scan_ok;  // scan_q holds real data
        logic [VLP_NITEM-1:0][5:0]     applied;  // lines in use
        logic [VLP_NITEM-1:0]          moved;    // request was clamped
        logic [5:0]                    ins;      // insertion strobes
    } vlp_state_t;

    vlp_state_t st;      // current state
    vlp_state_t next_st; // next state

    logic       mem_wr_en; // bus write into request store
    logic [2:0] mem_rd_a;  // bus read address into store
    logic [7:0] mem_a;     // bus read data from store
    logic [7:0] mem_b;     // scanner read data from store

    // request word window
    function automatic logic in_req(input logic [7:0] a);
        return (a >= VLP_OFS_REQ) && (a < VLP_OFS_REQ + 8'(4 * VLP_NITEM));
    endfunction : in_req

    // applied word window
    function automatic logic in_app(input logic [7:0] a);
        return (a >= VLP_OFS_APPLIED) && (a < VLP_OFS_APPLIED + 8'(4 * VLP_NITEM));
    endfunction : in_app

    // item number inside a window
    function automatic logic [2:0] item_of(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        return d[4:2];
    endfunction : item_of

    // ************************************************************
    // request store
    // ************************************************************
    vlp_line_mem vlp_line_mem_i (
        .clk       (REF_CLK),
        .nrst      (NRST),
        .wr_en     (mem_wr_en),
        .wr_addr   (item_of(st.aw_addr, VLP_OFS_REQ)),
        .wr_data   (st.w_data[7:0]),
        .rd_a_addr (mem_rd_a),
        .rd_a_data (mem_a),
        .rd_b_addr (st.scan),
        .rd_b_data (mem_b)
    );

    // bus write lands in store once both halves are held
    assign mem_wr_en = st.aw_held && st.w_held && !st.bvalid && in_req(st.aw_addr)
                       && st.w_strb[0];
    assign mem_rd_a  = item_of(st.ar_addr, VLP_OFS_REQ);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [VLP_NEV-1:0] ev;    // events raised this cycle
        logic [5:0]         want;  // requested or default line
        logic [5:0]         place; // line after limiting
        logic [5:0]         dflt;  // default line for the item
        logic [1:0]         lv;    // indicator level
        logic               sd;    // standard definition output
        ev      = '0;
        want    = VLP_L_NONE;
        place   = VLP_L_NONE;
        dflt    = VLP_L_NONE;
        lv      = VLP_LV_NORMAL;
        sd      = vlp_is_sd(st.fmt);
        next_st = st;

        // write address and data taken in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_st.w_held = 1'b1;
            next_st.w_data = S_AXI_WDATA;
            next_st.w_strb = S_AXI_WSTRB;
        end

        // both held: perform the write and answer
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = VLP_RESP_OKAY;
            if (st.aw_addr == VLP_OFS_CTRL) begin
                if (st.w_strb[0]) begin
                    next_st.enable = st.w_data[VLP_CTRL_EN];
                    next_st.fmt    = st.w_data[VLP_CTRL_FMT +: 3];
                end
            end else if (st.aw_addr == VLP_OFS_STATUS) begin
                // clear by writing ones
                if (st.w_strb[0]) begin
                    next_st.status = st.status & ~st.w_data[VLP_NEV-1:0];
                end
            end else if (st.aw_addr == VLP_OFS_MASK) begin
                if (st.w_strb[0]) begin
                    next_st.mask = st.w_data[VLP_NEV-1:0];
                end
            end else if (!in_req(st.aw_addr) && st.aw_addr != VLP_OFS_HEALTH
                         && !in_app(st.aw_addr)) begin
                // unmapped address
                next_st.bresp = VLP_RESP_SLVERR;
            end
        end
        if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid = 1'b0;
        end

        // read sequencer
        unique case (st.rd)
            VLP_RD_IDLE: begin
                if (S_AXI_ARVALID) begin
                    next_st.ar_addr = S_AXI_ARADDR;
                    next_st.rd      = VLP_RD_FETCH;
                end
            end
            VLP_RD_FETCH: begin
                // store is read in this cycle, registers sampled here
                next_st.rd    = VLP_RD_RESP;
                next_st.rresp = VLP_RESP_OKAY;
                next_st.rdata = 32'h0000_0000;
                if (st.ar_addr == VLP_OFS_CTRL) begin
                    next_st.rdata[VLP_CTRL_EN]       = st.enable;
                    next_st.rdata[VLP_CTRL_FMT +: 3] = st.fmt;
                end else if (st.ar_addr == VLP_OFS_STATUS) begin
                    next_st.rdata[VLP_NEV-1:0] = st.status;
                end else if (st.ar_addr == VLP_OFS_MASK) begin
                    next_st.rdata[VLP_NEV-1:0] = st.mask;
                end else if (st.ar_addr == VLP_OFS_HEALTH) begin
                    // three level indicators
                    lv = vlp_fmt_ok(st.fmt) ? VLP_LV_NORMAL : VLP_LV_FAILURE;
                    next_st.rdata[VLP_HL_FMT +: 2] = lv;
                    lv = (|st.moved) ? VLP_LV_ALERT : VLP_LV_NORMAL;
                    next_st.rdata[VLP_HL_PLACE +: 2] = lv;
                    lv = st.enable ? VLP_LV_NORMAL : VLP_LV_ALERT;
                    next_st.rdata[VLP_HL_INS +: 2] = lv;
                end else if (in_app(st.ar_addr)) begin
                    // the line really used, after limiting
                    next_st.rdata[5:0] = st.applied[item_of(st.ar_addr, VLP_OFS_APPLIED)];
                end else if (!in_req(st.ar_addr)) begin
                    next_st.rresp = VLP_RESP_SLVERR;
                end
            end
            VLP_RD_RESP: begin
                if (S_AXI_RREADY) begin
                    next_st.rd = VLP_RD_IDLE;
                end
            end
        endcase

        // scanner walks the items, one read per cycle
        next_st.scan    = (st.scan == 3'(VLP_NITEM - 1)) ? 3'h0 : st.scan + 3'h1;
        next_st.scan_q  = st.scan;
        next_st.scan_ok = 1'b1;
        if (st.scan_ok) begin
            dflt = vlp_default(st.scan_q, sd);
            want = (mem_b == VLP_RST_REQ) ? dflt : mem_b[5:0];
            if (!vlp_fmt_ok(st.fmt) || dflt == VLP_L_NONE) begin
                place = VLP_L_NONE;
            end else if (sd && st.scan_q == VLP_IT_CAP) begin
                place = VLP_L21;
            end else if (mem_b[7:6] != 2'h0 || want > vlp_hi(st.fmt)) begin
                place = vlp_hi(st.fmt);
            end else if (want < vlp_lo(st.fmt)) begin
                place = vlp_lo(st.fmt);
            end else begin
                place = want;
            end
            next_st.applied[st.scan_q] = place;
            next_st.moved[st.scan_q]   = (place != want) && (mem_b != VLP_RST_REQ)
                                         && (place != VLP_L_NONE);
            ev[VLP_EV_CLAMP] = next_st.moved[st.scan_q] && !st.moved[st.scan_q];
        end

        // each item fires on its own line; shared lines are not checked
        for (int i = 0; i < VLP_NITEM; i++) begin
            next_st.ins[i] = LINE_STB && st.enable && (st.applied[i] != VLP_L_NONE)
                             && (LINE_NUM == {5'h00, st.applied[i]});
        end
        ev[VLP_EV_INSERT] = |next_st.ins;
        ev[VLP_EV_BADFMT] = !vlp_fmt_ok(st.fmt);

        // set wins over a clear in the same cycle
        next_st.status = next_st.status | ev;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st         <= '0;
            st.rd      <= VLP_RD_IDLE;
            st.enable  <= VLP_RST_EN;
            st.fmt     <= VLP_RST_FMT;
            st.mask    <= VLP_RST_MASK;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign S_AXI_AWREADY = !st.aw_held && !st.bvalid;
    assign S_AXI_WREADY  = !st.w_held && !st.bvalid;
    assign S_AXI_BVALID  = st.bvalid;
    assign S_AXI_BRESP   = st.bresp;
    assign S_AXI_ARREADY = (st.rd == VLP_RD_IDLE);
    assign S_AXI_RVALID  = (st.rd == VLP_RD_RESP);
    assign S_AXI_RRESP   = st.rresp;
    // request words come straight from the store's output register
    assign S_AXI_RDATA   = in_req(st.ar_addr) ? {24'h000000, mem_a} : st.rdata;
    assign VANC_INS      = st.ins;
    assign IRQ           = |(st.status & st.mask);

endmodule : vlp_top

// *** tb/vlp_props.sv ***
`timescale 1ns/1ns
// ************************************************************
// placement checker on the top ports
// ************************************************************
module vlp_props
    import vlp_pkg::*;
(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        NRST,
    // video side
    input wire logic        LINE_STB,
    input wire logic [10:0] LINE_NUM,
    input wire logic [5:0]  VANC_INS,
    // read channels
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // read address accepted by the slave
    sequence ar_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // fetch cycle, then the answer
    sequence r_answer;
        !S_AXI_ARREADY ##1 S_AXI_RVALID;
    endsequence
    ins_cause_a: assert property (
        |VANC_INS |-> $past(LINE_STB)) else $error("pulse without line strobe");
    ins_single_a: assert property (
        !LINE_STB |=> VANC_INS == 6'h00) else $error("pulse longer than one cycle");
    wave_sd_a: assert property (
        VANC_INS[4] |-> $past(LINE_NUM) inside {[11'd9:11'd22]}) else $error("waveform off range");
    ltc_hd_a: assert property (
        VANC_INS[2] |-> $past(LINE_NUM) inside {[11'd9:11'd41]}) else $error("ltc off range");
    ins_range_a: assert property (
        |VANC_INS |-> $past(LINE_NUM) inside {[11'd9:11'd41]}) else $error("line off range");
    read_answer_a: assert property (
        ar_taken |=> r_answer) else $error("read answer late");
    read_hold_a: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
endmodule : vlp_props

bind vlp_top vlp_props vlp_props_i (.REF_CLK, .NRST, .LINE_STB, .LINE_NUM, .VANC_INS,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA);

// *** tb/vlp_sdi_sink.sv ***
`timescale 1ns/1ns
// ************************************************************
// downstream receiver: notes the line each item arrived on
// ************************************************************
module vlp_sdi_sink (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // output stream
    input  wire logic        line_stb,
    input  wire logic [10:0] line_num,
    input  wire logic [5:0]  vanc_ins,
    // per item line seen
    output logic      [10:0] seen [6]
);
    logic [10:0] cur; // line now being sent
    // accepts any number of items on one line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= 11'h000;
            seen <= '{default: 11'h000};
        end else begin
            if (line_stb) cur <= line_num;
            for (int i = 0; i < 6; i++) if (vanc_ins[i]) seen[i] <= cur;
        end
    end
endmodule : vlp_sdi_sink

// *** tb/vanc_line_placement_tb.sv ***
`timescale 1ns/1ns
// ************************************************************
// register driven placement bench
// ************************************************************
module vanc_line_placement_tb
    import vlp_pkg::*;
;
    logic clk = 0, nrst = 0, stb = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [10:0] num = 11'h000;
    logic [7:0]  aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, d;
    logic [1:0]  r, b;
    wire awr, wrdy, bv, arr, rv, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdat;
    wire [5:0] ins;
    wire [10:0] seen [6];
    int n_errors = 0, n_compared = 0;
    logic [5:0] dsd [6] = '{6'h0c, 6'h0d, 6'h00, 6'h0d, 6'h0e, 6'h15}; // sd defaults
    logic [5:0] dhd [6] = '{6'h09, 6'h09, 6'h0a, 6'h0d, 6'h00, 6'h0a}; // hd defaults
    logic [2:0] cf [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4}; // formats
    logic [7:0] rq [8] = '{8'h05, 8'h1e, 8'h05, 8'h1e, 8'h1e, 8'h3f, 8'h32, 8'h1e};
    logic [7:0] ce [8] = '{8'h0c, 8'h13, 8'h09, 8'h16, 8'h19, 8'h14, 8'h29, 8'h1e};
    always #10 clk = ~clk;
    vlp_top vlp_top_i (.REF_CLK(clk), .NRST(nrst), .LINE_STB(stb), .LINE_NUM(num),
        .VANC_INS(ins), .IRQ(irq), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_AWADDR(aw), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp));
    vlp_sdi_sink vlp_sdi_sink_i (.clk(clk), .nrst(nrst), .line_stb(stb), .line_num(num),
        .vanc_ins(ins), .seen(seen));
    // verdict and end of run
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge clk);
        aw <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        b = bresp;
        br <= 1'b0;
        if (k == 40) n_errors++;
        if (k == 40) conclude();
    endtask : wr
    // one bus read
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge clk);
        ar <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rdat;
        r = rresp;
        rr <= 1'b0;
        if (k == 40) n_errors++;
        if (k == 40) conclude();
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, d);
    endtask : rc
    // request and control writes, then let the applied lines settle
    task automatic setf(input logic [2:0] f, input logic en, input logic [7:0] q);
        wr(VLP_OFS_REQ, {24'h0, q});
        wr(VLP_OFS_CTRL, {28'h0, f, en});
        repeat (8) @(posedge clk);
    endtask : setf
    // one line strobe, pulses looked at the cycle after
    task automatic line(input logic [10:0] n, input logic [5:0] e);
        @(posedge clk);
        stb <= 1'b1;
        num <= n;
        @(posedge clk);
        stb <= 1'b0;
        #1;
        chk("insert", {26'h0, e}, {26'h0, ins});
    endtask : line
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rc(VLP_OFS_CTRL, 32'h0);
        rc(VLP_OFS_MASK, 32'h0);
        for (int f = 0; f < 5; f++) begin
            setf(3'(f), 1'b1, 8'h00);
            for (int i = 0; i < 6; i++)
                rc(8'(VLP_OFS_APPLIED + 4 * i), {26'h0, (f < 2) ? dsd[i] : dhd[i]});
        end
        for (int i = 0; i < 8; i++) begin
            setf(cf[i], 1'b1, rq[i]);
            rc(VLP_OFS_APPLIED, {24'h0, ce[i]});
            rc(VLP_OFS_REQ, {24'h0, rq[i]});
        end
        setf(VLP_F1080P, 1'b1, 8'h32);
        rc(VLP_OFS_HEALTH, 32'h04);
        wr(VLP_OFS_MASK, 32'h1);
        @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(VLP_OFS_MASK, 32'h0);
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        setf(VLP_F525I, 1'b1, 8'h0d);
        line(11'd13, 6'h0b);
        // sink notes the line one edge after the pulse
        @(posedge clk);
        #1;
        chk("sink", 32'd13, {21'h0, seen[3]});
        line(11'd21, 6'h20);
        line(11'd14, 6'h10);
        setf(VLP_F525I, 1'b0, 8'h0d);
        line(11'd13, 6'h00);
        rc(VLP_OFS_HEALTH, 32'h10);
        setf(3'h5, 1'b1, 8'h0d);
        line(11'd13, 6'h00);
        rd(VLP_OFS_HEALTH);
        chk("format level", 32'h2, {30'h0, d[1:0]});
        // clamp, insert and bad format all sticky; bad format set again each cycle
        rc(VLP_OFS_STATUS, 32'h7);
        wr(VLP_OFS_STATUS, 32'h3);
        rc(VLP_OFS_STATUS, 32'h4);
        rd(8'h10);
        chk("unmapped resp", 32'h2, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        wr(8'h10, 32'h1);
        chk("unmapped write", 32'h2, {30'h0, b});
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule : vanc_line_placement_tb
